/* File: design/sps_pkg.sv */
package sps_pkg;

    // ----------------------------------------------------------------
    // Soft-start and thresholds
    // ----------------------------------------------------------------
    localparam int unsigned SS_STEPS = 2048;
    localparam int unsigned SS_W = 12;
    localparam logic [11:0] SS_LAST = 12'h7ff;
    // Reference code width; each ramp step adds one 2048th of the final reference.
    localparam int unsigned REF_W = 12;
    localparam logic [11:0] REF_ZERO = 12'h000;
    // Reference code at which under-voltage checking starts (0.6 V on a 12-bit scale).
    localparam logic [11:0] UV_ENABLE_REF = 12'h2ea;
    localparam int unsigned SYNC_W = 6;
    localparam logic [5:0] SYNC_RST = 6'h00;

    // ----------------------------------------------------------------
    // Sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SPS_OFF,
        SPS_RAMP,
        SPS_RUN,
        SPS_HICCUP,
        SPS_CROWBAR
    } sps_state_e;

endpackage : sps_pkg

/* File: design/sps_sync_if.sv */
`timescale 1ns/10ps
interface sps_sync_if;
    logic [5:0] raw;
    logic [5:0] synced;
    modport src (output raw, input synced);
    modport snk (input raw, output synced);
endinterface : sps_sync_if

/* File: design/sps_sync.sv */
`timescale 1ns/10ps
module sps_sync
    import sps_pkg::*;
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Signals
    sps_sync_if.snk bus
);
    logic [SYNC_W-1:0] meta_ff;
    logic [SYNC_W-1:0] sync_ff;

    // Two stages; the first is read only by the second.
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            meta_ff <= SYNC_RST;
            sync_ff <= SYNC_RST;
        end
        else
        begin
            meta_ff <= bus.raw;
            sync_ff <= meta_ff;
        end
    end

    assign bus.synced = sync_ff;
endmodule : sps_sync

/* File: design/sps_softstart_protection_sequencer.sv */
`timescale 1ns/10ps
// Summary of operation
// - Power good low whenever sensed output is outside plus or minus twelve percent.
// - Power good low during soft-start; comparator used only after 2048 clocks.
// - Output below sixty percent for over one clock: all off, new soft-start.
// - With supply up, over-voltage latches both low sides on, high sides off.
// - Over-voltage drives fault pin high; cleared only by removing the main supply.
// - Under-voltage check waits for reference 0.6 V; over-voltage active with supply up and no inhibit.
// - Under-voltage threshold follows the ramp; over-voltage uses final reference.
// - Reference steps from zero to the selected final value in 2048 clocks.
// - Switching starts with the ramp; power good comparator enabled at ramp end.
// - Soft-start needs both control and driver supplies above turn-on threshold.
// - Either supply under-voltage during operation shuts the device down.
// - Inhibit turns off all transistors and protections while it persists, except the low sides of a latched crowbar.
// - The two phases switch 180 degrees apart.
module sps_softstart_protection_sequencer
    import sps_pkg::*;
#(
    parameter int unsigned REF_WIDTH = REF_W
)
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Supplies and inhibit
    input wire logic i_ctrl_supply_ok,
    input wire logic i_driver_supply_ok,
    input wire logic i_osc_inhibit_pin,
    // Output sense comparators
    input wire logic i_sense_in_window,
    input wire logic i_sense_below_uv,
    input wire logic i_sense_above_ov,
    // Reference and oscillator
    input wire logic [sps_pkg::REF_W-1:0] i_final_ref,
    input wire logic i_osc_phase,
    // Reference outputs
    output logic [sps_pkg::REF_W-1:0] o_loop_ref,
    output logic [sps_pkg::REF_W-1:0] o_uv_ref,
    output logic [sps_pkg::REF_W-1:0] o_ov_ref,
    // Status
    output logic o_power_good_out,
    output logic o_pin_a,
    output logic o_soft_start_busy,
    // Gate enables
    output logic o_hs1_en,
    output logic o_ls1_en,
    output logic o_hs2_en,
    output logic o_ls2_en,
    output logic o_pwm_run,
    output logic o_phase1_sel,
    output logic o_phase2_sel
);
    import sps_pkg::*;

    // ----------------------------------------------------------------
    // Input synchronisation
    // ----------------------------------------------------------------
    sps_sync_if sync_bus ();
    assign sync_bus.raw = {i_sense_above_ov, i_sense_below_uv, i_sense_in_window,
                           i_osc_inhibit_pin, i_driver_supply_ok, i_ctrl_supply_ok};

    sps_sync u_sync (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .bus(sync_bus.snk)
    );

    wire vcc_ok = sync_bus.synced[0];
    wire vdr_ok = sync_bus.synced[1];
    wire inhibit = sync_bus.synced[2];
    wire in_window = sync_bus.synced[3];
    wire below_uv = sync_bus.synced[4];
    wire above_ov = sync_bus.synced[5];

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    sps_state_e state_ff;
    sps_state_e nxt_state;
    logic [SS_W-1:0] ss_cnt_ff;
    logic [SS_W-1:0] nxt_ss_cnt;
    logic uv_seen_ff;
    logic pg_ff;
    logic [REF_W-1:0] ref_ff;

    function automatic logic [REF_W-1:0] ramp_ref(input logic [SS_W-1:0] cnt,
                                                 input logic [REF_W-1:0] fin);
        logic [REF_W+SS_W-1:0] prod;
        prod = fin * ({1'b0, cnt} + (REF_W+SS_W)'(1));
        ramp_ref = prod[REF_W+SS_W-2 -: REF_W];
    endfunction : ramp_ref

    wire supplies_ok = vcc_ok && vdr_ok;
    // Inhibit overrides everything except an already latched crowbar, which only power clears.
    wire disable_all = inhibit || !supplies_ok;
    wire ramping = (state_ff == SPS_RAMP);
    wire ramp_done = ramping && (ss_cnt_ff == SS_LAST);
    wire uv_armed = (state_ff == SPS_RUN) || (ramping && (ref_ff >= UV_ENABLE_REF));
    // A single sample below threshold is tolerated; the second consecutive one trips.
    wire uv_trip = uv_armed && below_uv && uv_seen_ff;
    wire ov_trip = vcc_ok && !inhibit && above_ov;

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_comb
    begin
        nxt_state = state_ff;
        nxt_ss_cnt = ss_cnt_ff;
        case (state_ff)
            SPS_OFF:
            begin
                nxt_ss_cnt = '0;
                if (ov_trip)
                    nxt_state = SPS_CROWBAR;
                else if (!disable_all)
                    nxt_state = SPS_RAMP;
            end
            SPS_RAMP:
            begin
                nxt_ss_cnt = ss_cnt_ff + SS_W'(1);
                if (!vcc_ok)
                    nxt_state = SPS_OFF;
                else if (ov_trip)
                    nxt_state = SPS_CROWBAR;
                else if (disable_all)
                    nxt_state = SPS_OFF;
                else if (uv_trip)
                    nxt_state = SPS_HICCUP;
                else if (ramp_done)
                    nxt_state = SPS_RUN;
            end
            SPS_RUN:
            begin
                if (!vcc_ok)
                    nxt_state = SPS_OFF;
                else if (ov_trip)
                    nxt_state = SPS_CROWBAR;
                else if (disable_all)
                    nxt_state = SPS_OFF;
                else if (uv_trip)
                    nxt_state = SPS_HICCUP;
            end
            SPS_HICCUP:
            begin
                // One cycle with everything off here, a further one in SPS_OFF, then a fresh ramp.
                nxt_ss_cnt = '0;
                nxt_state = SPS_OFF;
            end
            SPS_CROWBAR:
            begin
                if (!vcc_ok)
                    nxt_state = SPS_OFF;
            end
            default:
            begin
                nxt_state = SPS_OFF;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_ff <= SPS_OFF;
            ss_cnt_ff <= '0;
            uv_seen_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            ss_cnt_ff <= nxt_ss_cnt;
            uv_seen_ff <= uv_armed && below_uv;
        end
    end

    // ----------------------------------------------------------------
    // References and power good
    // ----------------------------------------------------------------
    wire [REF_W-1:0] nxt_ref = (nxt_state == SPS_RAMP) ? ramp_ref(nxt_ss_cnt, i_final_ref)
                             : (nxt_state == SPS_RUN) ? i_final_ref : REF_ZERO;
    wire nxt_pg = (state_ff == SPS_RUN) && (nxt_state == SPS_RUN) && in_window;

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            ref_ff <= REF_ZERO;
            pg_ff <= 1'b0;
        end
        else
        begin
            ref_ff <= nxt_ref;
            pg_ff <= nxt_pg;
        end
    end

    assign o_loop_ref = ref_ff;
    assign o_uv_ref = ref_ff;
    assign o_ov_ref = i_final_ref;
    assign o_power_good_out = pg_ff;
    assign o_soft_start_busy = ramping;

    // ----------------------------------------------------------------
    // Gate enables
    // ----------------------------------------------------------------
    // The crowbar keeps both low sides on even under inhibit, because only a loss of the
    // control supply may release the latch; shorting the output is the safe state.
    wire crowbar = (state_ff == SPS_CROWBAR);
    wire switching = ramping || (state_ff == SPS_RUN);
    assign o_pin_a = crowbar;
    assign o_pwm_run = switching;
    assign o_hs1_en = switching;
    assign o_hs2_en = switching;
    assign o_ls1_en = switching || crowbar;
    assign o_ls2_en = switching || crowbar;
    assign o_phase1_sel = switching && i_osc_phase;
    assign o_phase2_sel = switching && !i_osc_phase;
endmodule : sps_softstart_protection_sequencer

/* File: testbench/sps_chk.sv */
`timescale 1ns/10ps
module sps_chk
    import sps_pkg::*;
#(
    parameter int unsigned REF_WIDTH = REF_W
)
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_ctrl_supply_ok,
    input wire logic i_driver_supply_ok,
    input wire logic i_osc_inhibit_pin,
    input wire logic i_sense_in_window,
    input wire logic i_sense_below_uv,
    input wire logic i_sense_above_ov,
    input wire logic [sps_pkg::REF_W-1:0] i_final_ref,
    input wire logic i_osc_phase,
    input wire logic [sps_pkg::REF_W-1:0] o_loop_ref,
    input wire logic [sps_pkg::REF_W-1:0] o_uv_ref,
    input wire logic [sps_pkg::REF_W-1:0] o_ov_ref,
    input wire logic o_power_good_out,
    input wire logic o_pin_a,
    input wire logic o_soft_start_busy,
    input wire logic o_hs1_en,
    input wire logic o_ls1_en,
    input wire logic o_hs2_en,
    input wire logic o_ls2_en,
    input wire logic o_pwm_run,
    input wire logic o_phase1_sel,
    input wire logic o_phase2_sel
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    // Counting ramp cycles here keeps the 2048 figure out of a repetition.
    logic [12:0] ramp_cnt_ff;
    always_ff @(posedge i_clk_sys or posedge i_rst)
        if (i_rst) ramp_cnt_ff <= 13'h0000;
        else ramp_cnt_ff <= o_soft_start_busy ? ramp_cnt_ff + 13'h0001 : 13'h0000;
    pg_window_a: assert property (o_power_good_out |-> $past(i_sense_in_window, 3))
        else $error("power good high outside window");
    ramp_len_a: assert property ($fell(o_soft_start_busy) && o_pwm_run |->
        ramp_cnt_ff == 13'h0800)
        else $error("ramp length wrong");
    ramp_drive_a: assert property (o_soft_start_busy |->
        o_hs1_en && o_ls2_en && !o_power_good_out)
        else $error("ramp drive or power good wrong");
    final_ref_a: assert property (o_pwm_run && !o_soft_start_busy |->
        o_loop_ref == i_final_ref)
        else $error("loop reference not final");
    ov_ref_a: assert property (o_ov_ref == i_final_ref)
        else $error("over-voltage reference wrong");
    crowbar_gates_a: assert property (o_pin_a |->
        !o_hs1_en && !o_hs2_en && o_ls1_en && o_ls2_en)
        else $error("crowbar gate states wrong");
    crowbar_hold_a: assert property (i_ctrl_supply_ok[*4] ##0 o_pin_a |=> o_pin_a)
        else $error("fault latch cleared");
    inhibit_off_a: assert property (i_osc_inhibit_pin[*4] |->
        !o_hs1_en && !o_hs2_en && !o_pwm_run)
        else $error("switching while inhibited");
    start_gate_a: assert property ($rose(o_soft_start_busy) |->
        $past(i_ctrl_supply_ok, 3) && $past(i_driver_supply_ok, 3))
        else $error("ramp started without supplies");
    uv_hiccup_a: assert property ((o_pwm_run && !o_soft_start_busy && i_sense_below_uv)[*3] |->
        ##[0:4] !o_pwm_run)
        else $error("no hiccup on under-voltage");
    phase_split_a: assert property (o_pwm_run |->
        (o_phase1_sel ^ o_phase2_sel) && o_phase1_sel == i_osc_phase)
        else $error("phases not interleaved");
    ramp_c: cover property ($fell(o_soft_start_busy) && o_pwm_run);
    crowbar_c: cover property ($rose(o_pin_a));
    hiccup_c: cover property (o_pwm_run ##1 !o_pwm_run ##[1:8] o_soft_start_busy);
endmodule : sps_chk
bind sps_softstart_protection_sequencer sps_chk #(.REF_WIDTH(REF_WIDTH)) u_chk (.*);

/* File: testbench/sps_plant.sv */
`timescale 1ns/10ps
module sps_plant
(
    input wire logic i_hs_en,
    input wire logic [1:0] i_mode,
    output logic o_in_window,
    output logic o_below_uv,
    output logic o_above_ov
);
    // The output only sits in its window while the high sides switch.
    assign o_in_window = i_hs_en && (i_mode == 2'h0);
    assign o_below_uv = i_mode == 2'h1;
    assign o_above_ov = i_mode == 2'h2;
endmodule : sps_plant

/* File: testbench/test_softstart_protection_sequencer.sv */
`timescale 1ns/10ps
module test_softstart_protection_sequencer;
    import sps_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    logic i_ctrl_supply_ok = 1'b0, i_driver_supply_ok = 1'b0, i_osc_inhibit_pin = 1'b0;
    logic i_osc_phase = 1'b0;
    logic [1:0] mode = 2'h0;
    logic [11:0] i_final_ref = 12'h400;
    wire i_sense_in_window, i_sense_below_uv, i_sense_above_ov;
    logic [11:0] o_loop_ref, o_uv_ref, o_ov_ref;
    logic o_power_good_out, o_pin_a, o_soft_start_busy, o_hs1_en, o_ls1_en, o_hs2_en;
    logic o_ls2_en, o_pwm_run, o_phase1_sel, o_phase2_sel;
    int num_errors = 0;
    int checked = 0;
    int k;
    logic [31:0] seed = 32'h1a09;
    always #10 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) i_osc_phase <= ~i_osc_phase;
    sps_softstart_protection_sequencer dut (.*);
    sps_plant u_plant (.i_hs_en(o_hs1_en), .i_mode(mode), .o_in_window(i_sense_in_window),
        .o_below_uv(i_sense_below_uv), .o_above_ov(i_sense_above_ov));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    function automatic logic [11:0] ramp_exp(input int unsigned steps, input logic [11:0] fin);
        return 12'((32'(fin) * steps) / SS_STEPS);
    endfunction : ramp_exp
    task automatic check_ref(input logic [11:0] got, input logic [11:0] exp);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: reference %h expected %h", $time, got, exp);
        end
    endtask : check_ref
    task automatic check_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: status %b expected %b", $time, got, exp);
        end
    endtask : check_bit
    task automatic check_cnt(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: count %0d expected %0d", $time, got, exp);
        end
    endtask : check_cnt
    task automatic give_verdict;
        if (num_errors == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask : cyc
    task automatic wait_busy(input logic v, output int n);
        n = 0;
        while (o_soft_start_busy !== v && n < 3000)
        begin
            cyc(1);
            n++;
        end
        check_bit(o_soft_start_busy, v);
    endtask : wait_busy
    initial
    begin
        cyc(8);
        i_rst <= 1'b0;
        i_ctrl_supply_ok <= 1'b1;
        cyc(20);
        check_bit(o_soft_start_busy, 1'b0);
        for (int n = 0; n < 3; n++)
        begin
            seed = xs(seed);
            i_final_ref <= (n == 2) ? 12'hfff : seed[11:0];
            i_driver_supply_ok <= 1'b1;
            wait_busy(1'b1, k);
            check_bit(o_hs1_en && o_ls1_en, 1'b1);
            wait_busy(1'b0, k);
            check_cnt(k, SS_STEPS);
            cyc(3);
            check_ref(o_loop_ref, i_final_ref);
            check_ref(o_uv_ref, i_final_ref);
            check_ref(o_ov_ref, i_final_ref);
            check_bit(o_power_good_out, 1'b1);
            if (n == 0) mode <= 2'h1;
            if (n == 1) i_osc_inhibit_pin <= 1'b1;
            if (n == 2) mode <= 2'h3;
            cyc(4);
            check_bit(o_power_good_out, 1'b0);
            if (n == 1) check_bit(o_hs1_en || o_pwm_run, 1'b0);
            if (n == 0) check_bit(o_pwm_run, 1'b0);
            mode <= 2'h0;
            i_osc_inhibit_pin <= 1'b0;
            if (n != 2)
            begin
                wait_busy(1'b1, k);
                wait_busy(1'b0, k);
            end
            else
            begin
                cyc(4);
                check_bit(o_power_good_out, 1'b1);
            end
            i_driver_supply_ok <= 1'b0;
            cyc(4);
            check_bit(o_hs1_en || o_pwm_run, 1'b0);
        end
        i_driver_supply_ok <= 1'b1;
        wait_busy(1'b1, k);
        cyc(1023);
        check_ref(o_loop_ref, ramp_exp(1024, i_final_ref));
        check_ref(o_uv_ref, ramp_exp(1024, i_final_ref));
        check_bit(o_power_good_out, 1'b0);
        mode <= 2'h2;
        cyc(4);
        mode <= 2'h0;
        check_bit(o_pin_a, 1'b1);
        check_bit(o_hs1_en || o_hs2_en, 1'b0);
        check_bit(o_ls1_en && o_ls2_en, 1'b1);
        i_osc_inhibit_pin <= 1'b1;
        cyc(6);
        i_osc_inhibit_pin <= 1'b0;
        check_bit(o_pin_a, 1'b1);
        i_ctrl_supply_ok <= 1'b0;
        cyc(6);
        check_bit(o_pin_a, 1'b0);
        give_verdict();
    end
    initial
    begin
        repeat (40000) @(posedge i_clk_sys);
        num_errors++;
        give_verdict();
    end
endmodule : test_softstart_protection_sequencer
